// *** hdl/ubcs_pkg.sv ***
// Package with register map, field layout and reset values of the baud clock block
package ubcs_pkg;
    localparam int          UBCS_NCH          = 2;
    localparam int          UBCS_AW           = 5;
    localparam int          UBCS_DIVW         = 7;
    localparam int          UBCS_CODEW        = 4;
    localparam int          UBCS_PRESCW       = 15;
    localparam logic [4:0]  UBCS_OFF_PRESC    = 5'h00;
    localparam logic [4:0]  UBCS_OFF_MODE0    = 5'h04;
    localparam logic [4:0]  UBCS_OFF_MODE1    = 5'h08;
    localparam logic [4:0]  UBCS_OFF_DATA0    = 5'h0c;
    localparam logic [4:0]  UBCS_OFF_DATA1    = 5'h10;
    localparam logic [4:0]  UBCS_OFF_START    = 5'h14;
    localparam logic [4:0]  UBCS_OFF_STOP     = 5'h18;
    localparam logic [4:0]  UBCS_OFF_STATUS   = 5'h1c;
    localparam int          UBCS_FIRST_LSB    = 0;
    localparam int          UBCS_SECOND_LSB   = 4;
    localparam int          UBCS_PICK_BIT     = 15;
    localparam int          UBCS_RXMODE_BIT   = 0;
    localparam int          UBCS_DIV_LSB      = 9;
    localparam int          UBCS_STAT_RUN     = 0;
    localparam int          UBCS_STAT_BAUD    = 2;
    localparam int          UBCS_STAT_RXBUSY  = 4;
    localparam logic [15:0] UBCS_PRESC_RST    = 16'h0000;
    localparam logic [15:0] UBCS_MODE_RST     = 16'h0000;
    localparam logic [15:0] UBCS_DATA_RST     = 16'hfe00;
    localparam logic [1:0]  UBCS_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  UBCS_RESP_SLVERR  = 2'h2;
    typedef enum logic {UBCS_RX_IDLE, UBCS_RX_FRAME} ubcs_rx_e;
endpackage

// *** hdl/ubcs_tick_if.sv ***
// Interface between the register top and one channel divider
`timescale 1ns/100ps
interface ubcs_tick_if;
    import ubcs_pkg::*;
    logic                 run;
    logic                 mck_tick;
    logic                 restart;
    logic [UBCS_DIVW-1:0] div_val;
    logic                 bit_tick;
    logic                 sample_tick;
    logic                 baud_level;
    modport top (output run, mck_tick, restart, div_val,
                 input  bit_tick, sample_tick, baud_level);
    modport div (input  run, mck_tick, restart, div_val,
                 output bit_tick, sample_tick, baud_level);
endinterface

// *** hdl/ubcs_baud_div.sv ***
// Channel divider: operation clock ticks to half-bit phase, bit and sample pulses
`timescale 1ns/100ps
module ubcs_baud_div
    import ubcs_pkg::*;
(
    input  wire logic  clk_sys,
    input  wire logic  rst_n,
    ubcs_tick_if.div   tk
);
    logic [UBCS_DIVW-1:0] cnt_reg,   cnt_next;
    logic                 phase_reg, phase_next;
    logic                 bit_reg,   bit_next;
    logic                 smp_reg,   smp_next;
    logic                 wrap;

    assign wrap = tk.mck_tick && (cnt_reg == tk.div_val);

    always_comb begin
        cnt_next   = cnt_reg;
        phase_next = phase_reg;
        bit_next   = 1'b0;
        smp_next   = 1'b0;
        if (tk.restart || !tk.run) begin
            cnt_next   = '0;
            phase_next = 1'b0;
        end else if (wrap) begin // [R01]
            cnt_next   = '0;
            phase_next = ~phase_reg;
            bit_next   = phase_reg; // [R09]
            smp_next   = ~phase_reg; // [R08]
        end else if (tk.mck_tick) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg   <= '0;
            phase_reg <= 1'b0;
            bit_reg   <= 1'b0;
            smp_reg   <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            phase_reg <= phase_next;
            bit_reg   <= bit_next;
            smp_reg   <= smp_next;
        end
    end

    assign tk.bit_tick    = bit_reg;
    assign tk.sample_tick = smp_reg;
    assign tk.baud_level  = phase_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checking helpers: operation ticks since the last bit pulse or restart
    logic [8:0] since_bit_reg;
    logic [8:0] since_rst_reg;
    logic       seen_reg;
    logic       first_smp_reg;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            since_bit_reg <= '0;
            since_rst_reg <= '0;
            seen_reg      <= 1'b0;
            first_smp_reg <= 1'b0;
        end else if (tk.restart || !tk.run || $changed(tk.div_val)) begin
            since_bit_reg <= '0;
            since_rst_reg <= '0;
            seen_reg      <= 1'b0;
            first_smp_reg <= tk.restart;
        end else begin
            if (tk.mck_tick) begin
                since_bit_reg <= wrap && phase_reg ? 9'h000 : since_bit_reg + 9'h001;
                since_rst_reg <= since_rst_reg + 9'h001;
            end
            if (wrap && phase_reg) begin
                seen_reg <= 1'b1;
            end
            if (smp_reg) begin
                first_smp_reg <= 1'b0;
            end
        end
    end

    bit_period_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R01]
        (wrap && phase_reg && seen_reg && !tk.restart && tk.run && !$changed(tk.div_val))
        |-> (since_bit_reg + 9'h001 == 9'({tk.div_val, 1'b1} + 8'h01)))
        else $error("bit period differs from twice divider plus one");
    first_sample_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R08]
        (smp_reg && first_smp_reg) |-> (since_rst_reg == 9'(tk.div_val) + 9'h001))
        else $error("first sample not at half a bit after start");
    pulse_width_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R09]
        bit_reg |=> !bit_reg ##1 !bit_reg)
        else $error("bit pulse longer than one cycle");
    pulse_excl_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R09]
        !(bit_reg && smp_reg))
        else $error("bit and sample pulse together");
    stop_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R06]
        !tk.run |=> !bit_reg && !smp_reg && !phase_reg)
        else $error("stopped channel still pulses");
endmodule

// *** hdl/ubcs_top.sv ***
// Baud clock select top: AXI4-Lite registers, prescalers, channel dividers, rx timing
// Behaviour
// [R01] Bit rate is the operation clock divided by divider plus one, then by two.
// [R02] Software never writes divider values zero or one.
// [R03] The divider sits in bits 15 to 9 of the channel data word, values 2 to 127.
// [R04] Source pick bit 15 of the mode word chooses first (0) or second (1) prescaler.
// [R05] Each prescaler divides the system clock by two to the power of its 4-bit code.
// [R06] Software stops all channels before changing the system clock source.
// [R07] Clock selection applies independently to channel 0 and channel 1.
// [R08] After a start bit the receiver times each bit latch from the divider.
// [R09] Prescaler and divider outputs are one-cycle enables, not derived clocks; the divider also drives baud_level, a half-bit phase level.
`timescale 1ns/100ps
module ubcs_top
    import ubcs_pkg::*;
#(
    parameter int FRAME_BITS = 11
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic [UBCS_AW-1:0]   s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [UBCS_AW-1:0]   s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic [UBCS_NCH-1:0]  rxd,
    output logic [UBCS_NCH-1:0]       bit_tick,
    output logic [UBCS_NCH-1:0]       sample_tick,
    output logic [UBCS_NCH-1:0]       baud_level
);
    function automatic logic presc_tick(input logic [UBCS_PRESCW-1:0] cnt,
                                        input logic [UBCS_CODEW-1:0]  code);
        logic [UBCS_PRESCW-1:0] mask;
        mask = (UBCS_PRESCW'(1) << code) - UBCS_PRESCW'(1);
        return (cnt & mask) == mask; // [R05]
    endfunction

    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  strb);
        lane_merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register bus
    logic [15:0]              presc_reg, presc_next;
    logic [15:0]              mode_reg  [UBCS_NCH], mode_next [UBCS_NCH];
    logic [15:0]              data_reg  [UBCS_NCH], data_next [UBCS_NCH];
    logic [UBCS_NCH-1:0]      run_reg,   run_next;
    logic                     aw_hold_reg, aw_hold_next;
    logic                     w_hold_reg,  w_hold_next;
    logic [UBCS_AW-1:0]       awaddr_reg,  awaddr_next;
    logic [31:0]              wdata_reg,   wdata_next;
    logic [3:0]               wstrb_reg,   wstrb_next;
    logic                     bvalid_reg,  bvalid_next;
    logic [1:0]               bresp_reg,   bresp_next;
    logic                     rvalid_reg,  rvalid_next;
    logic [1:0]               rresp_reg,   rresp_next;
    logic [31:0]              rdata_reg,   rdata_next;
    logic [UBCS_NCH-1:0]      rx_busy;

    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;

    always_comb begin
        logic [15:0] stat;
        stat         = '0;
        presc_next   = presc_reg;
        mode_next    = mode_reg;
        data_next    = data_reg;
        run_next     = run_reg;
        aw_hold_next = aw_hold_reg;
        w_hold_next  = w_hold_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg && !s_axi_bready;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg && !s_axi_rready;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
        end
        if (aw_hold_reg && w_hold_reg) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = UBCS_RESP_OKAY;
            case ({awaddr_reg[UBCS_AW-1:2], 2'b00})
                UBCS_OFF_PRESC: presc_next = lane_merge(presc_reg, wdata_reg, wstrb_reg);
                UBCS_OFF_MODE0: mode_next[0] = lane_merge(mode_reg[0], wdata_reg, wstrb_reg);
                UBCS_OFF_MODE1: mode_next[1] = lane_merge(mode_reg[1], wdata_reg, wstrb_reg);
                UBCS_OFF_DATA0: data_next[0] = lane_merge(data_reg[0], wdata_reg, wstrb_reg);
                UBCS_OFF_DATA1: data_next[1] = lane_merge(data_reg[1], wdata_reg, wstrb_reg);
                UBCS_OFF_START: run_next = run_reg | (wstrb_reg[0] ? wdata_reg[1:0] : 2'h0);
                UBCS_OFF_STOP:  run_next = run_reg & ~(wstrb_reg[0] ? wdata_reg[1:0] : 2'h0);
                UBCS_OFF_STATUS: begin
                end
                default: bresp_next = UBCS_RESP_SLVERR;
            endcase
        end
        stat[UBCS_STAT_RUN +: UBCS_NCH]    = run_reg;
        stat[UBCS_STAT_BAUD +: UBCS_NCH]   = baud_level;
        stat[UBCS_STAT_RXBUSY +: UBCS_NCH] = rx_busy;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next  = UBCS_RESP_OKAY;
            case ({s_axi_araddr[UBCS_AW-1:2], 2'b00})
                UBCS_OFF_PRESC:  rdata_next = {16'h0000, presc_reg};
                UBCS_OFF_MODE0:  rdata_next = {16'h0000, mode_reg[0]};
                UBCS_OFF_MODE1:  rdata_next = {16'h0000, mode_reg[1]};
                UBCS_OFF_DATA0:  rdata_next = {16'h0000, data_reg[0]};
                UBCS_OFF_DATA1:  rdata_next = {16'h0000, data_reg[1]};
                UBCS_OFF_START:  rdata_next = {30'h0, run_reg};
                UBCS_OFF_STOP:   rdata_next = 32'h0000_0000;
                UBCS_OFF_STATUS: rdata_next = {16'h0000, stat};
                default: begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = UBCS_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg   <= UBCS_PRESC_RST;
            mode_reg    <= '{default: UBCS_MODE_RST};
            data_reg    <= '{default: UBCS_DATA_RST};
            run_reg     <= '0;
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= UBCS_RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= UBCS_RESP_OKAY;
            rdata_reg   <= '0;
        end else begin
            presc_reg   <= presc_next;
            mode_reg    <= mode_next;
            data_reg    <= data_next;
            run_reg     <= run_next;
            aw_hold_reg <= aw_hold_next;
            w_hold_reg  <= w_hold_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp  = rresp_reg;
    assign s_axi_rdata  = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Shared prescaler; a free counter keeps both outputs phase-related
    logic [UBCS_PRESCW-1:0] pcnt_reg, pcnt_next;
    logic                   first_prescaler_out;
    logic                   second_prescaler_out;

    assign pcnt_next            = pcnt_reg + 1'b1;
    assign first_prescaler_out  = presc_tick(pcnt_reg, presc_reg[UBCS_FIRST_LSB +: UBCS_CODEW]);
    assign second_prescaler_out = presc_tick(pcnt_reg, presc_reg[UBCS_SECOND_LSB +: UBCS_CODEW]);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pcnt_reg <= '0;
        end else begin
            pcnt_reg <= pcnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel clock pick, start detection and divider
    logic [1:0]          rx_meta_reg [UBCS_NCH];
    logic [UBCS_NCH-1:0] rx_prev_reg;
    ubcs_rx_e            rx_st_reg   [UBCS_NCH], rx_st_next [UBCS_NCH];
    logic [7:0]          rx_cnt_reg  [UBCS_NCH], rx_cnt_next [UBCS_NCH];

    for (genvar ch = 0; ch < UBCS_NCH; ch++) begin : g_ch
        ubcs_tick_if tk ();
        logic start_seen;

        assign tk.run      = run_reg[ch];
        assign tk.mck_tick = mode_reg[ch][UBCS_PICK_BIT] ? second_prescaler_out
                                                         : first_prescaler_out; // [R04] [R07]
        assign tk.div_val  = data_reg[ch][UBCS_DIV_LSB +: UBCS_DIVW]; // [R03]
        // Divider values 0 and 1 are left to software and give no documented rate [R02]
        assign start_seen  = rx_prev_reg[ch] && !rx_meta_reg[ch][1]
                             && mode_reg[ch][UBCS_RXMODE_BIT] && run_reg[ch];
        assign tk.restart  = (rx_st_reg[ch] == UBCS_RX_IDLE) && start_seen; // [R08]
        assign bit_tick[ch]    = tk.bit_tick;
        assign sample_tick[ch] = tk.sample_tick;
        assign baud_level[ch]  = tk.baud_level;
        assign rx_busy[ch]     = (rx_st_reg[ch] == UBCS_RX_FRAME);

        always_comb begin
            rx_st_next[ch]  = rx_st_reg[ch];
            rx_cnt_next[ch] = rx_cnt_reg[ch];
            case (rx_st_reg[ch])
                UBCS_RX_IDLE: begin
                    if (tk.restart) begin
                        rx_st_next[ch]  = UBCS_RX_FRAME;
                        rx_cnt_next[ch] = '0;
                    end
                end
                UBCS_RX_FRAME: begin
                    if (!run_reg[ch]) begin
                        rx_st_next[ch] = UBCS_RX_IDLE;
                    end else if (tk.sample_tick) begin // [R08]
                        rx_cnt_next[ch] = rx_cnt_reg[ch] + 8'h01;
                        if (rx_cnt_reg[ch] == 8'(FRAME_BITS - 1)) begin
                            rx_st_next[ch] = UBCS_RX_IDLE;
                        end
                    end
                end
                default: rx_st_next[ch] = UBCS_RX_IDLE;
            endcase
        end

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                rx_meta_reg[ch] <= 2'h3;
                rx_prev_reg[ch] <= 1'b1;
                rx_st_reg[ch]   <= UBCS_RX_IDLE;
                rx_cnt_reg[ch]  <= '0;
            end else begin
                rx_meta_reg[ch] <= {rx_meta_reg[ch][0], rxd[ch]};
                rx_prev_reg[ch] <= rx_meta_reg[ch][1];
                rx_st_reg[ch]   <= rx_st_next[ch];
                rx_cnt_reg[ch]  <= rx_cnt_next[ch];
            end
        end

        ubcs_baud_div u_div (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .tk      (tk.div)
        );

        clk_pick_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R04]
            tk.mck_tick == (mode_reg[ch][UBCS_PICK_BIT] ? second_prescaler_out
                                                        : first_prescaler_out))
            else $error("operation clock from wrong prescaler");
        div_field_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R03]
            (bvalid_next && !bvalid_reg && bresp_next == UBCS_RESP_OKAY && wstrb_reg[1]
             && {awaddr_reg[UBCS_AW-1:2], 2'b00} == (ch == 0 ? UBCS_OFF_DATA0 : UBCS_OFF_DATA1))
            |=> tk.div_val == $past(wdata_reg[15:9]))
            else $error("divider not taken from bits 15 to 9");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on prescalers and bus
    sequence s_one_tick;
        first_prescaler_out ##1 !first_prescaler_out;
    endsequence

    presc_full_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R05]
        (presc_reg[3:0] == 4'h0) |-> first_prescaler_out)
        else $error("code zero must pass every cycle");
    // A code rewrite mid-pattern drops the attempt instead of flagging it
    presc_half_a: assert property (@(posedge clk_sys) // [R05]
        disable iff (!rst_n || presc_reg[3:0] != 4'h2)
        (presc_reg[3:0] == 4'h2 && first_prescaler_out && $stable(presc_reg))
        |-> s_one_tick ##1 !first_prescaler_out ##1 !first_prescaler_out ##1 first_prescaler_out)
        else $error("code two must pulse every fourth cycle");
    resp_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
endmodule

// *** tb/ubcs_tx_model.sv ***
// Remote serial transmitter driving one receive line with start, data and stop bits
`timescale 1ns/100ps
module ubcs_tx_model (
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic [15:0] bit_cycles,
    input  wire logic [8:0]  payload,
    output logic             line
);
    logic [10:0] frame;
    // Line idles at the stop level, so the receiver sees no false start
    initial line = 1'b1;
    always @(posedge clk_sys) begin
        if (go) begin
            frame = {1'b1, payload, 1'b0};
            for (int b = 0; b < 11; b++) begin
                line <= frame[b];
                repeat (bit_cycles) @(posedge clk_sys);
            end
            line <= 1'b1;
        end
    end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench: registers, per-channel bit rate, receive timing, stop
`timescale 1ns/100ps
module tb_top;
    import ubcs_pkg::*;
    logic        clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready, go, line;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d, seed;
    logic [1:0]  bresp, rresp, r, bit_tick, sample_tick, baud_level;
    logic [8:0]  payload;
    int          n_errors, checks, cyc, ch, c0, c1, pick, dv, expv, t0, n;

    ubcs_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd({line, 1'b1}),
        .bit_tick(bit_tick), .sample_tick(sample_tick), .baud_level(baud_level));
    ubcs_tx_model peer_u (.clk_sys(clk_sys), .go(go), .bit_cycles(16'h0008),
        .payload(payload), .line(line));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] ex);
        checks++;
        if (seen !== ex) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, ex, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Handshakes judged at the negedge, where registered readies are settled
    task automatic axw(input logic [4:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk_sys);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk_sys);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
        check("bresp", 32'(r), 32'(UBCS_RESP_OKAY));
    endtask
    task automatic axr(input logic [4:0] a);
        logic ta, tr;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk_sys);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk_sys);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
        rready <= 1'b0;
    endtask
    task automatic wait_hi(input int c, input bit smp);
        do @(negedge clk_sys);
        while (!(smp ? sample_tick[c] === 1'b1 : bit_tick[c] === 1'b1));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, go, rst_n} = '0;
        {awaddr, araddr, wdata, payload} = '0;
        {n_errors, checks, cyc} = '0;
        seed = 32'h24;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        axr(UBCS_OFF_DATA0);
        check("data0 reset", d, 32'h0000fe00);
        axr(UBCS_OFF_MODE1);
        check("mode1 reset", d, 32'h0);
        axr(UBCS_OFF_PRESC);
        check("presc reset", d, 32'h0);
        // Every word slot of the 5-bit space is mapped; low bits only alias
        axr(5'h02);
        check("aliased resp", 32'(r), 32'(UBCS_RESP_OKAY));
        axw(UBCS_OFF_START, 32'h3);
        for (int i = 0; i < 6; i++) begin
            ch = i % 2;
            c0 = xs() % 3;
            c1 = xs() % 3;
            pick = xs() % 2;
            // Corner dividers first; never 0 or 1
            dv = (i == 0) ? 2 : (i == 1) ? 127 : 2 + xs() % 20;
            axw(UBCS_OFF_PRESC, {24'h0, c1[3:0], c0[3:0]});
            axw(ch ? UBCS_OFF_MODE1 : UBCS_OFF_MODE0, {16'h0, pick[0], 15'h0});
            axw(ch ? UBCS_OFF_DATA1 : UBCS_OFF_DATA0, {16'h0, dv[6:0], 9'h0});
            expv = (2 * (dv + 1)) << (pick ? c1 : c0);
            wait_hi(ch, 0);
            wait_hi(ch, 0);
            t0 = cyc;
            wait_hi(ch, 0);
            check("bit period", cyc - t0, expv);
            wait_hi(ch, 1);
            check("level at sample", 32'(baud_level[ch]), 32'h1);
            t0 = cyc;
            wait_hi(ch, 0);
            check("half period", cyc - t0, expv / 2);
            check("level at bit", 32'(baud_level[ch]), 32'h0);
        end
        axw(UBCS_OFF_PRESC, 32'h0);
        axw(UBCS_OFF_MODE1, 32'h1);
        axw(UBCS_OFF_DATA1, {16'h0, 7'h03, 9'h0});
        @(posedge clk_sys);
        go <= 1'b1;
        payload <= 9'(xs());
        @(posedge clk_sys);
        go <= 1'b0;
        do @(negedge clk_sys);
        while (line);
        t0 = cyc;
        // Skip the synchroniser delay, before which no restart can land
        repeat (4) @(negedge clk_sys);
        wait_hi(1, 1);
        // Two sync stages and the edge register, then divider plus one ticks
        check("first sample", cyc - t0, 32'h7);
        t0 = cyc;
        wait_hi(1, 1);
        check("sample spacing", cyc - t0, 8);
        axr(UBCS_OFF_STATUS);
        check("rx busy", 32'(d[5]), 32'h1);
        repeat (120) @(posedge clk_sys);
        axr(UBCS_OFF_STATUS);
        check("rx idle", 32'(d[5]), 32'h0);
        axw(UBCS_OFF_STOP, 32'hf);
        axr(UBCS_OFF_STATUS);
        check("run cleared", 32'(d[1:0]), 32'h0);
        n = 0;
        repeat (300) begin
            @(negedge clk_sys);
            n += 32'(|bit_tick);
        end
        check("ticks after stop", n, 0);
        tally_and_finish();
    end
endmodule
